// file: inc/bls_pkg.sv
// Purpose: constants for the bridge window and secondary status bank
// Assumes: 32-bit register bus, byte addresses on word boundaries
// Notes:   shared by the bank top and its two leaf modules
//
// Contract
// R1: I/O limit bits 11:8 read 1h
// R2: I/O limit bits 15:12 writable top address
// R3: I/O top bound low 12 bits ones
// R4: I/O top bits 31:16 from upper register
// R5: status bits 21, 23, 26:25 read zero
// R6: bit 24 set on secondary parity error
// R7: parity flag gated by response enable
// R8: bit 27 set on completer abort sent
// R9: bit 28 set on completer abort received
// R10: bit 29 set on unsupported request received
// R11: bit 30 set on error message, SERR on
// R12: bit 31 set on poisoned packet received
// R13: memory base bits 15:4 writable, reset zero
// R14: memory bottom bound low 20 bits zero
// R15: windows decide memory forwarding
// R16: memory top from limit, low bits ones
// R17: I/O bottom from base, low bits zero
// R18: write one clears, event wins; bits 27..29 do not clear by write, only on reset
// R19: reserved bits read zero, writes ignored
package bls_pkg;

    // =====================================================================
    // bus geometry
    localparam int unsigned REG_AW = 8;
    localparam int unsigned REG_DW = 32;

    // =====================================================================
    // register byte offsets
    localparam logic [REG_AW-1:0] OFS_IO_STAT   = 8'h1c;
    localparam logic [REG_AW-1:0] OFS_MEM_WIN   = 8'h20;
    localparam logic [REG_AW-1:0] OFS_CTRL      = 8'h40;
    localparam logic [REG_AW-1:0] OFS_IRQ_STAT  = 8'h44;
    localparam logic [REG_AW-1:0] OFS_IRQ_CLR   = 8'h48;
    localparam logic [REG_AW-1:0] OFS_IRQ_EN    = 8'h4c;

    // =====================================================================
    // field positions in the 0x1c word
    localparam int unsigned IO_BASE_LSB    = 4;
    localparam int unsigned IO_LIM_IND_LSB = 8;
    localparam int unsigned IO_LIM_LSB     = 12;
    localparam logic [3:0]  IO_32BIT_IND   = 4'h1;
    localparam logic [3:0]  IO_FIELD_RST   = 4'h0;

    // sticky flag positions in the 0x1c word
    localparam int unsigned ST_PAR_BIT  = 24;
    localparam int unsigned ST_CAS_BIT  = 27;
    localparam int unsigned ST_CAR_BIT  = 28;
    localparam int unsigned ST_URR_BIT  = 29;
    localparam int unsigned ST_SER_BIT  = 30;
    localparam int unsigned ST_PSN_BIT  = 31;

    // event vector index, shared by status flags and interrupt bank
    localparam int unsigned EV_N   = 6;
    localparam int unsigned EV_PAR = 0;
    localparam int unsigned EV_CAS = 1;
    localparam int unsigned EV_CAR = 2;
    localparam int unsigned EV_URR = 3;
    localparam int unsigned EV_SER = 4;
    localparam int unsigned EV_PSN = 5;

    // flags that software may clear by writing one
    localparam logic [EV_N-1:0] EV_W1C_MASK = 6'h31;

    // =====================================================================
    // memory window word
    localparam int unsigned MEM_BASE_LSB = 4;
    localparam int unsigned MEM_LIM_LSB  = 20;
    localparam logic [11:0] MEM_FIELD_RST = 12'h000;

    // =====================================================================
    // control register bits
    localparam int unsigned CTL_PERR_EN = 0;
    localparam int unsigned CTL_SERR_EN = 1;
    localparam logic [1:0]  CTL_RST     = 2'h0;

    // low address bits implied by the bounds
    localparam logic [11:0] IO_LOW_ONES  = 12'hfff;
    localparam logic [11:0] IO_LOW_ZERO  = 12'h000;
    localparam logic [19:0] MEM_LOW_ONES = 20'hfffff;
    localparam logic [19:0] MEM_LOW_ZERO = 20'h00000;

endpackage

// file: rtl/bls_sticky_bank.sv
// Purpose: bank of sticky flags, set by events, cleared by a mask
// Assumes: set and clear come from logic on the same clock
// Notes:   a set in the cycle of a clear keeps the flag high
`timescale 1ns/1ps
`default_nettype none
module bls_sticky_bank #(
    parameter int unsigned N = 6
) (
    input  wire logic         clk_i,    // core clock
    input  wire logic         arst_n_i, // async reset, low
    input  wire logic [N-1:0] set_i,    // event pulses
    input  wire logic [N-1:0] clr_i,    // clear pulses
    output logic      [N-1:0] q_o       // flag state
);
    import bls_pkg::*;

    // =====================================================================
    // one flop per flag
    for (genvar g = 0; g < N; g++) begin : g_flag
        // R18: set beats clear
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                q_o[g] <= 1'b0;
            end else if (set_i[g]) begin
                q_o[g] <= 1'b1;
            end else if (clr_i[g]) begin
                q_o[g] <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/bls_window_cmp.sv
// Purpose: inclusive address range check for one forwarding window
// Assumes: bounds already expanded to full width
// Notes:   an empty window (base above limit) never hits
`timescale 1ns/1ps
`default_nettype none
module bls_window_cmp #(
    parameter int unsigned AW = 32
) (
    input  wire logic [AW-1:0] base_i,  // lowest address in window
    input  wire logic [AW-1:0] limit_i, // highest address in window
    input  wire logic [AW-1:0] addr_i,  // address under test
    output logic               hit_o    // address inside window
);
    import bls_pkg::*;

    // compare against both bounds
    assign hit_o = (addr_i >= base_i) && (addr_i <= limit_i);
endmodule
`default_nettype wire

// file: rtl/bls_bank.sv
// Purpose: I/O limit, secondary status and memory window registers
// Assumes: register bus and event sources share clk_i
// Notes:   forwarding check result is registered, one cycle latency
//          flags 27..29 clear only on reset
//          unmapped words read zero, writes drop
//          a set beats a clear in both flag banks
`timescale 1ns/1ps
`default_nettype none
module bls_bank (
    input  wire logic                          clk_i,        // core clock
    input  wire logic                          arst_n_i,     // reset, low
    // register port
    input  wire logic [bls_pkg::REG_AW-1:0]    reg_addr_i,   // byte address
    input  wire logic [bls_pkg::REG_DW-1:0]    reg_wdata_i,  // write data
    input  wire logic                          reg_wr_i,     // write strobe
    input  wire logic                          reg_rd_i,     // read strobe
    output logic      [bls_pkg::REG_DW-1:0]    reg_rdata_o,  // read data
    // events from the forwarding logic, one-cycle pulses
    input  wire logic                          par_err_ev_i, // parity err
    input  wire logic                          ca_sent_ev_i, // abort sent
    input  wire logic                          ca_rcvd_ev_i, // abort rcvd
    input  wire logic                          ur_rcvd_ev_i, // UR rcvd
    input  wire logic                          err_msg_ev_i, // err message
    input  wire logic                          poison_ev_i,  // poisoned TLP
    // upper I/O address halves from the upper-address registers
    input  wire logic [15:0]                   io_base_hi_i, // base 31:16
    input  wire logic [15:0]                   io_lim_hi_i,  // limit 31:16
    // forwarding query
    input  wire logic                          fwd_valid_i,  // query valid
    input  wire logic                          fwd_is_io_i,  // 1 io, 0 mem
    input  wire logic [31:0]                   fwd_addr_i,   // address
    output logic                               fwd_done_o,   // answer valid
    output logic                               fwd_hit_o,    // forward it
    // window bounds for the datapath
    output logic      [31:0]                   io_lo_o,      // io bottom
    output logic      [31:0]                   io_hi_o,      // io top
    output logic      [31:0]                   mem_lo_o,     // mem bottom
    output logic      [31:0]                   mem_hi_o,     // mem top
    output logic                               irq_o         // interrupt
);
    import bls_pkg::*;

    // =====================================================================
    // address decode
    // exact byte match, no aliasing of words
    function automatic logic is_ofs(input logic [REG_AW-1:0] a,
                                    input logic [REG_AW-1:0] o);
        is_ofs = (a == o);
    endfunction

    // 0x44 has no write select, so writes there drop
    logic wr_io_stat;
    logic wr_mem_win;
    logic wr_ctrl;
    logic wr_irq_clr;
    logic wr_irq_en;

    // write selects per register
    // strobes never overlap, so reads need no select
    assign wr_io_stat = reg_wr_i && is_ofs(reg_addr_i, OFS_IO_STAT);
    assign wr_mem_win = reg_wr_i && is_ofs(reg_addr_i, OFS_MEM_WIN);
    assign wr_ctrl    = reg_wr_i && is_ofs(reg_addr_i, OFS_CTRL);
    assign wr_irq_clr = reg_wr_i && is_ofs(reg_addr_i, OFS_IRQ_CLR);
    assign wr_irq_en  = reg_wr_i && is_ofs(reg_addr_i, OFS_IRQ_EN);

    // =====================================================================
    // writable fields
    // only stored bits have flops; fixed bits are constants
    logic [3:0]      io_base_r;
    logic [3:0]      io_lim_r;
    logic [11:0]     mem_base_r;
    logic [11:0]     mem_lim_r;
    logic [1:0]      ctrl_r;
    logic [EV_N-1:0] irq_en_r;

    // I/O base and limit fields of the 0x1c word
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_base_r <= IO_FIELD_RST;
            io_lim_r  <= IO_FIELD_RST;
        end else if (wr_io_stat) begin
            // base bits 7:4, bottom of the I/O window
            io_base_r <= reg_wdata_i[IO_BASE_LSB +: 4];
            // R2: limit bits 15:12
            io_lim_r  <= reg_wdata_i[IO_LIM_LSB +: 4];
        end
    end

    // memory window word; bits 3:0 and 19:16 are not stored
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_base_r <= MEM_FIELD_RST;
            mem_lim_r  <= MEM_FIELD_RST;
        end else if (wr_mem_win) begin
            // R13: base bits 15:4
            mem_base_r <= reg_wdata_i[MEM_BASE_LSB +: 12];
            // R16: limit bits 31:20
            mem_lim_r  <= reg_wdata_i[MEM_LIM_LSB +: 12];
        end
    end

    // error response controls
    // both off at reset, so gated events drop at first
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_r <= CTL_RST;
        end else if (wr_ctrl) begin
            // bit 0 parity response enable
            // bit 1 error message enable
            ctrl_r <= reg_wdata_i[1:0];
        end
    end

    // interrupt enables
    // these mask irq_o only; flags set regardless
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_en_r <= '0;
        end else if (wr_irq_en) begin
            irq_en_r <= reg_wdata_i[EV_N-1:0];
        end
    end

    // =====================================================================
    // event qualification
    logic [EV_N-1:0] ev_set;

    // gating sits ahead of both flag banks, so a
    // disabled source leaves nothing to clear later
    always_comb begin
        ev_set = '0;

        // R6: parity error on secondary side
        // R7: gated by response enable
        ev_set[EV_PAR] = par_err_ev_i && ctrl_r[CTL_PERR_EN];

        // R8: completer abort sent
        ev_set[EV_CAS] = ca_sent_ev_i;

        // R9: completer abort received
        ev_set[EV_CAR] = ca_rcvd_ev_i;

        // R10: unsupported request received
        ev_set[EV_URR] = ur_rcvd_ev_i;

        // R11: error message with SERR on
        ev_set[EV_SER] = err_msg_ev_i && ctrl_r[CTL_SERR_EN];

        // R12: poisoned packet received
        ev_set[EV_PSN] = poison_ev_i;
    end

    // =====================================================================
    // secondary status flags
    logic [EV_N-1:0] st_clr;
    logic [EV_N-1:0] st_q;

    // pick up the write-one-to-clear bits of the status half
    // only a 0x1c write clears; bits 27..29 are masked
    always_comb begin
        st_clr = '0;

        if (wr_io_stat) begin
            st_clr[EV_PAR] = reg_wdata_i[ST_PAR_BIT];
            st_clr[EV_CAS] = reg_wdata_i[ST_CAS_BIT];
            st_clr[EV_CAR] = reg_wdata_i[ST_CAR_BIT];
            st_clr[EV_URR] = reg_wdata_i[ST_URR_BIT];
            st_clr[EV_SER] = reg_wdata_i[ST_SER_BIT];
            st_clr[EV_PSN] = reg_wdata_i[ST_PSN_BIT];
        end

        // read-only flags ignore the write
        st_clr = st_clr & EV_W1C_MASK;
    end

    // R18: sticky status with set priority
    // these are the flags that software reads at 0x1c
    bls_sticky_bank #(
        .N (EV_N)
    ) u_status (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .set_i    (ev_set),
        .clr_i    (st_clr),
        .q_o      (st_q)
    );

    // =====================================================================
    // interrupt status, cleared through the clear register
    logic [EV_N-1:0] irq_clr;
    logic [EV_N-1:0] irq_st;
    logic [EV_N-1:0] irq_pend;

    // 0x48 is write only; a one clears that flag
    assign irq_clr = wr_irq_clr ? reg_wdata_i[EV_N-1:0] : '0;

    // own copy of the flags, so clearing the
    // interrupt leaves the status bits alone
    bls_sticky_bank #(
        .N (EV_N)
    ) u_irq (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .set_i    (ev_set),
        .clr_i    (irq_clr),
        .q_o      (irq_st)
    );

    // flags that are both set and enabled
    assign irq_pend = irq_st & irq_en_r;

    // level interrupt while any enabled flag is set
    // registered, so irq_o cannot glitch
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |irq_pend;
        end
    end

    // =====================================================================
    // window bounds
    // combinational, so a register write shows up
    // in the forwarding decision one cycle later
    // R17: io bottom low bits zero
    // R4: io upper bits from outside
    assign io_lo_o  = {io_base_hi_i, io_base_r, IO_LOW_ZERO};

    // R3: io top low bits ones
    assign io_hi_o  = {io_lim_hi_i, io_lim_r, IO_LOW_ONES};

    // R14: memory bottom low bits zero
    assign mem_lo_o = {mem_base_r, MEM_LOW_ZERO};

    // R16: memory top low bits ones
    assign mem_hi_o = {mem_lim_r, MEM_LOW_ONES};

    // =====================================================================
    // forwarding decision
    // raw compare results, before the query type
    logic io_hit;
    logic mem_hit;
    logic win_hit;

    // I/O window, 32-bit bounds
    bls_window_cmp #(
        .AW (32)
    ) u_io_win (
        .base_i  (io_lo_o),
        .limit_i (io_hi_o),
        .addr_i  (fwd_addr_i),
        .hit_o   (io_hit)
    );

    // memory window; an empty one never hits
    bls_window_cmp #(
        .AW (32)
    ) u_mem_win (
        .base_i  (mem_lo_o),
        .limit_i (mem_hi_o),
        .addr_i  (fwd_addr_i),
        .hit_o   (mem_hit)
    );

    // pick the window named by the query
    assign win_hit = fwd_is_io_i ? io_hit : mem_hit;

    // R15: registered window verdict
    // done follows valid; hit only beside valid
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fwd_done_o <= 1'b0;
            fwd_hit_o  <= 1'b0;
        end else begin
            fwd_done_o <= fwd_valid_i;
            fwd_hit_o  <= fwd_valid_i && win_hit;
        end
    end

    // =====================================================================
    // read mux
    logic [REG_DW-1:0] rd_word;

    // fields sit at their word positions, the
    // rest of each word stays zero
    always_comb begin
        rd_word = '0;
        case (reg_addr_i)
            OFS_IO_STAT: begin
                // R1: fixed 32-bit I/O indicator
                rd_word[IO_BASE_LSB-4 +: 4]  = IO_32BIT_IND;
                rd_word[IO_BASE_LSB +: 4]    = io_base_r;
                rd_word[IO_LIM_IND_LSB +: 4] = IO_32BIT_IND;
                rd_word[IO_LIM_LSB +: 4]     = io_lim_r;

                // R5: bits 21, 23, 26:25 stay zero
                // R19: bits 20:16 and 22 stay zero
                // sticky flags, bits 24 and 27 to 31
                rd_word[ST_PAR_BIT] = st_q[EV_PAR];
                rd_word[ST_CAS_BIT] = st_q[EV_CAS];
                rd_word[ST_CAR_BIT] = st_q[EV_CAR];
                rd_word[ST_URR_BIT] = st_q[EV_URR];
                rd_word[ST_SER_BIT] = st_q[EV_SER];
                rd_word[ST_PSN_BIT] = st_q[EV_PSN];
            end
            OFS_MEM_WIN: begin
                // R19: base bits 3:0 read zero
                // bits 19:16 read zero as well
                rd_word[MEM_BASE_LSB +: 12] = mem_base_r;
                rd_word[MEM_LIM_LSB +: 12]  = mem_lim_r;
            end
            // error response controls
            OFS_CTRL: begin
                rd_word[1:0] = ctrl_r;
            end
            // interrupt flags, read only
            OFS_IRQ_STAT: begin
                rd_word[EV_N-1:0] = irq_st;
            end
            // interrupt enables
            OFS_IRQ_EN: begin
                rd_word[EV_N-1:0] = irq_en_r;
            end
            // 0x48 and unmapped words read zero
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // read data valid only in the cycle after the strobe
    // zero otherwise, so stale words never linger
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_word;
        end else begin
            reg_rdata_o <= '0;
        end
    end
endmodule
`default_nettype wire

// file: tb/bls_bank_props.sv
// Purpose: port-level checks on the window and status bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   read data is looked at in the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module bls_bank_props (
    input wire logic                       clk_i,       // core clock
    input wire logic                       arst_n_i,    // reset, low
    input wire logic [bls_pkg::REG_AW-1:0] reg_addr_i,  // byte address
    input wire logic [bls_pkg::REG_DW-1:0] reg_wdata_i, // write data
    input wire logic                       reg_wr_i,    // write strobe
    input wire logic                       reg_rd_i,    // read strobe
    input wire logic [bls_pkg::REG_DW-1:0] reg_rdata_o, // read data
    input wire logic                       ca_sent_ev_i, // abort sent
    input wire logic                       poison_ev_i, // poisoned
    input wire logic [15:0]                io_base_hi_i, // io base hi
    input wire logic [15:0]                io_lim_hi_i, // io top hi
    input wire logic                       fwd_valid_i, // query valid
    input wire logic                       fwd_is_io_i, // query kind
    input wire logic [31:0]                fwd_addr_i,  // query address
    input wire logic                       fwd_done_o,  // answer valid
    input wire logic                       fwd_hit_o,   // verdict
    input wire logic [31:0]                io_lo_o,     // io bottom
    input wire logic [31:0]                io_hi_o,     // io top
    input wire logic [31:0]                mem_lo_o,    // mem bottom
    input wire logic [31:0]                mem_hi_o     // mem top
);
    import bls_pkg::*;
    logic hit_exp_r;
    logic hit_exp_nxt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // ==========================================================
    // expected forwarding verdict, taken at the query edge
    always_comb begin
        hit_exp_nxt = fwd_is_io_i
            ? (fwd_addr_i >= io_lo_o && fwd_addr_i <= io_hi_o)
            : (fwd_addr_i >= mem_lo_o && fwd_addr_i <= mem_hi_o);
    end
    // registered copy of the verdict
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hit_exp_r <= 1'b0;
        end else begin
            hit_exp_r <= hit_exp_nxt;
        end
    end
    sequence s_rd_stat;
        reg_rd_i && reg_addr_i == OFS_IO_STAT;
    endsequence
    sequence s_clr_psn;
        reg_wr_i && reg_addr_i == OFS_IO_STAT && reg_wdata_i[31]
            && !poison_ev_i;
    endsequence
    AST_IO_IND: assert property (
        s_rd_stat |=> reg_rdata_o[11:8] == 4'h1)
        else $error("io limit indicator not 1");
    AST_HARD_ZERO: assert property (
        s_rd_stat |=> {reg_rdata_o[26:25], reg_rdata_o[23],
        reg_rdata_o[21]} == 4'h0)
        else $error("hardwired status bits not zero");
    AST_RSVD_ZERO: assert property (
        s_rd_stat |=> {reg_rdata_o[22], reg_rdata_o[20:16]} == 6'h00)
        else $error("reserved status bits not zero");
    AST_IO_TOP: assert property (
        io_hi_o[11:0] == 12'hfff && io_hi_o[31:16] == io_lim_hi_i)
        else $error("io top bound malformed");
    AST_IO_BOT: assert property (
        io_lo_o[11:0] == 12'h000 && io_lo_o[31:16] == io_base_hi_i)
        else $error("io bottom bound malformed");
    AST_MEM_BOUNDS: assert property (
        mem_lo_o[19:0] == 20'h00000 && mem_hi_o[19:0] == 20'hfffff)
        else $error("memory bound low bits wrong");
    AST_POISON_SET: assert property (
        poison_ev_i ##1 !reg_wr_i ##1 s_rd_stat |=> reg_rdata_o[31])
        else $error("poisoned flag not set");
    AST_CA_SENT_SET: assert property (
        ca_sent_ev_i ##2 s_rd_stat |=> reg_rdata_o[27])
        else $error("abort sent flag not set");
    AST_W1C_CLEAR: assert property (
        s_clr_psn ##1 !poison_ev_i ##1 (s_rd_stat and !poison_ev_i)
        |=> !reg_rdata_o[31])
        else $error("flag not cleared by writing one");
    AST_FWD_VERDICT: assert property (
        fwd_valid_i |=> fwd_done_o && fwd_hit_o == hit_exp_r)
        else $error("forwarding verdict wrong");
endmodule
bind bls_bank bls_bank_props u_props (.clk_i, .arst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ca_sent_ev_i,
    .poison_ev_i, .io_base_hi_i, .io_lim_hi_i, .fwd_valid_i, .fwd_is_io_i,
    .fwd_addr_i, .fwd_done_o, .fwd_hit_o, .io_lo_o, .io_hi_o, .mem_lo_o,
    .mem_hi_o);
`default_nettype wire

// file: tb/tb.sv
// Purpose: directed bench for the window and status bank
// Assumes: all inputs driven on the rising edge
// Notes:   events come in as one vector in interrupt bit order
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bls_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [5:0]  ev = 6'h00;
    logic        fv = 1'b0;
    logic        fio = 1'b0;
    logic [31:0] faddr = 32'h0;
    logic [15:0] bhi = 16'h0001;
    logic [15:0] lhi = 16'h0002;
    logic        fdone, fhit, irq;
    logic [31:0] io_lo, io_hi, mem_lo, mem_hi;
    int          mismatches = 0;
    int          checked = 0;
    int unsigned pos [6] = '{ST_PAR_BIT, ST_CAS_BIT, ST_CAR_BIT,
                             ST_URR_BIT, ST_SER_BIT, ST_PSN_BIT};
    logic [31:0] qa [8] = '{32'h0fff_ffff, 32'h1000_0000, 32'h1fff_ffff,
        32'h2000_0000, 32'h0001_1fff, 32'h0001_2000, 32'h0002_3fff,
        32'h0002_4000};
    logic [7:0]  qh = 8'b0110_0110;
    bls_bank u_dut (.clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .par_err_ev_i(ev[EV_PAR]),
        .ca_sent_ev_i(ev[EV_CAS]), .ca_rcvd_ev_i(ev[EV_CAR]),
        .ur_rcvd_ev_i(ev[EV_URR]), .err_msg_ev_i(ev[EV_SER]),
        .poison_ev_i(ev[EV_PSN]), .io_base_hi_i(bhi),
        .io_lim_hi_i(lhi), .fwd_valid_i(fv), .fwd_is_io_i(fio),
        .fwd_addr_i(faddr), .fwd_done_o(fdone), .fwd_hit_o(fhit),
        .io_lo_o(io_lo), .io_hi_o(io_hi), .mem_lo_o(mem_lo),
        .mem_hi_o(mem_hi), .irq_o(irq));
    // 25 MHz clock
    always #20 clk = ~clk;
    // ==========================================================
    // compare and verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // bus, event and query drivers
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 6'h00;
    endtask
    task automatic query(input logic io, input logic [31:0] a,
                         input logic e);
        @(posedge clk);
        fv <= 1'b1;
        fio <= io;
        faddr <= a;
        @(posedge clk);
        fv <= 1'b0;
        #1 chk({31'h0, fdone}, 32'h1);
        chk({31'h0, fhit}, {31'h0, e});
    endtask
    // hang guard
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(OFS_IO_STAT, 32'hffff_ffff, 32'h0000_0101);
        rd_chk(OFS_MEM_WIN, 32'hffff_ffff, 32'h0);
        wr_reg(OFS_IO_STAT, 32'hffff_ffff);
        rd_chk(OFS_IO_STAT, 32'hffff_ffff, 32'h0000_f1f1);
        wr_reg(OFS_MEM_WIN, 32'hffff_ffff);
        rd_chk(OFS_MEM_WIN, 32'hffff_ffff, 32'hfff0_fff0);
        chk(mem_lo, 32'hfff0_0000);
        chk(mem_hi, 32'hffff_ffff);
        chk(io_hi, 32'h0002_ffff);
        chk(io_lo, 32'h0001_f000);
        pulse(EV_PAR);
        pulse(EV_SER);
        rd_chk(OFS_IO_STAT, 32'h4100_0000, 32'h0);
        wr_reg(OFS_CTRL, 32'h3);
        wr_reg(OFS_IRQ_EN, 32'h3f);
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            rd_chk(OFS_IO_STAT, 32'h1 << pos[i], 32'h1 << pos[i]);
        end
        chk({31'h0, irq}, 32'h1);
        rd_chk(OFS_IRQ_STAT, 32'hffff_ffff, 32'h3f);
        // write one clears, read-only flags stay
        wr_reg(OFS_IO_STAT, 32'hff00_f0f0);
        rd_chk(OFS_IO_STAT, 32'hffff_ffff, 32'h3800_f1f1);
        wr_reg(OFS_IRQ_CLR, 32'h3f);
        wr_reg(OFS_IRQ_EN, 32'h0);
        rd_chk(OFS_IRQ_STAT, 32'hffff_ffff, 32'h0);
        pulse(EV_PSN);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h0);
        wr_reg(OFS_IRQ_EN, 32'h20);
        repeat (2) @(posedge clk);
        #1 chk({31'h0, irq}, 32'h1);
        wr_reg(OFS_IO_STAT, 32'h8000_f0f0);
        rd_chk(OFS_IO_STAT, 32'h8000_0000, 32'h0);
        // event wins over a clear in the same cycle
        @(posedge clk);
        wr <= 1'b1;
        addr <= OFS_IO_STAT;
        wdata <= 32'h8000_f0f0;
        ev[EV_PSN] <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        ev <= 6'h00;
        rd_chk(OFS_IO_STAT, 32'h8000_0000, 32'h8000_0000);
        wr_reg(8'h80, 32'hffff_ffff);
        rd_chk(8'h80, 32'hffff_ffff, 32'h0);
        // window edges for memory then io
        wr_reg(OFS_MEM_WIN, 32'h1ff0_1000);
        wr_reg(OFS_IO_STAT, 32'h0000_3020);
        for (int i = 0; i < 8; i++) begin
            query(i >= 4, qa[i], qh[i]);
        end
        // upper I/O halves follow their inputs
        @(posedge clk);
        bhi <= 16'h00a5;
        lhi <= 16'h005a;
        @(posedge clk);
        #1 chk(io_lo, 32'h00a5_2000);
        chk(io_hi, 32'h005a_3fff);
        give_verdict();
    end
endmodule
`default_nettype wire
